// ---- shared/crm_map.svh ----
// Constants of the counter rate window monitor: offsets, fields, resets, timing.
// Assumes inclusion by crm_top only; plain defines, no logic.
// Behaviour
// R1: Window length 1..9999 ms in 1 ms steps, set as four BCD digits.
// R2: Rate is signed count at window end minus count at window start.
// R3: Window setting zero, the reset value, stops rate measurement.
// R4: A counter preset or reset leaves the reported rate unchanged.
// R5: Ring counter rollover inside a window still gives the right difference.
// R6: Window length deviates typically 125 us, never above 1 ms.
// R7: History keeps the 64 newest rates, two 16-bit words each.
// R8: With a full history each new rate overwrites the oldest one.
// R9: Host reads 1..64 history entries; entry zero is the newest rate.
// R10: Two rate ranges, each lower, upper, set pattern, reset pattern.
// R11: Error flag when a range upper limit is not above its lower limit.
// R12: Error flag when the two ranges overlap.
// R13: Range active when lower <= rate <= upper; activity readable by host.
// R14: Limits are signed 32-bit two's complement values.
// R15: Patterns are 32-bit masks; bits 0-1 physical, 2-31 soft outputs.
// R16: Active range: set bit sets output, reset bit clears, zero keeps.
// R17: Active enabled range patterns override the unit output pattern.
// R18: Each range has an enable, clear at reset; disabled ranges do nothing. Code still updates their range_active bit and cfg_err flags.
// R19: Hysteresis 1..255 counts per counter; smaller swings are ignored.
// R20: Range activity must not toggle on small swings around a limit.
// R21: Hysteresis acts in range mode only, never in comparison mode.
// R22: Host should turn hysteresis off before presetting the counter.
// R23: Windows run back to back; each end sample starts the next window.
`ifndef CRM_MAP_SVH
`define CRM_MAP_SVH

// Register byte offsets
`define CRM_CTRL_OFS    6'h00
`define CRM_WIN_OFS     6'h04
`define CRM_HYST_OFS    6'h08
`define CRM_STAT_OFS    6'h0C
`define CRM_RATE_OFS    6'h10
`define CRM_HSEL_OFS    6'h14
`define CRM_HDAT_OFS    6'h18
`define CRM_RING_OFS    6'h1C
`define CRM_RNG0_OFS    6'h20
`define CRM_RNG1_OFS    6'h30

// Control fields
`define CRM_CTRL_EN0    0
`define CRM_CTRL_EN1    1
`define CRM_CTRL_RMODE  2
`define CRM_CTRL_RING   3

// Reset values
`define CRM_CTRL_RST    4'h0
`define CRM_WIN_RST     16'h0000
`define CRM_HYST_RST    8'h00
`define CRM_RING_RST    32'hFFFFFFFF

// Timing and history depth
`define CRM_CLK_PS      5000
`define CRM_MS_PS       1000000000
`define CRM_HIST_DEPTH  64

`endif

// ---- shared/crm_pkg.sv ----
// Types of the counter rate window monitor.
// Assumes the constants header for field meanings.
package crm_pkg;

    // Measurement phase
    typedef enum logic [1:0] {
        CRM_IDLE = 2'b00,
        CRM_ARM  = 2'b01,
        CRM_RUN  = 2'b10
    } crm_phase_t;

    // One rate range
    typedef struct packed {
        logic [31:0] lo;
        logic [31:0] hi;
        logic [31:0] setp;
        logic [31:0] rstp;
    } crm_range_t;

    // Whole state of the block
    typedef struct packed {
        crm_phase_t            ph;
        logic [31:0]           tick;
        logic [13:0]           wcnt;
        logic [31:0]           start;
        logic [31:0]           rate;
        logic [63:0][31:0]     hist;
        logic [5:0]            wptr;
        logic [6:0]            hcnt;
        logic [3:0]            ctrl;
        logic [15:0]           wbcd;
        logic [7:0]            hyst;
        logic [31:0]           ring;
        logic [1:0][127:0]     rng;
        logic [1:0]            act;
        logic [2:0]            err;
        logic [31:0]           outp;
        logic                  push;
        logic [5:0]            hsel;
        logic [5:0]            waddr;
        logic                  wpend;
        logic [31:0]           rdata;
    } crm_state_t;

endpackage : crm_pkg

// ---- rtl/crm_top.sv ----
// Rate monitor for one counter: windowed rate, history, two rate ranges.
// Assumes count_in, count_load and unit_pat come from logic on hclk.
`timescale 1ns/10ps
`include "crm_map.svh"

module crm_top #(
    parameter int MS_CYCLES = `CRM_MS_PS / `CRM_CLK_PS
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Counter side
    input  wire logic [31:0] count_in,
    input  wire logic        count_load,
    input  wire logic [31:0] unit_pat,
    // Results
    output logic [31:0]      out_pat,
    output logic [1:0]       range_active,
    output logic [2:0]       cfg_err
);

    // Refuse a millisecond shorter than one clock at elaboration
    if (MS_CYCLES < 1) begin : g_bad_ms
        $error("MS_CYCLES must be at least one");
    end

    crm_pkg::crm_state_t q;
    crm_pkg::crm_state_t d;

    ////////////////////////////////////////////////////////////////////
    // Combinational helpers

    logic [13:0]         wlen;
    logic                ms_tick;
    logic                win_end;
    logic signed [33:0]  raw;
    logic signed [33:0]  span;
    logic signed [33:0]  half;
    logic signed [33:0]  fixed;
    logic                rd_go;
    logic                wr_go;
    logic [5:0]          rofs;
    logic [31:0]         rv;
    logic [5:0]          hidx;
    logic signed [33:0]  lo_s [2];
    logic signed [33:0]  hi_s [2];
    logic signed [33:0]  r_s;
    logic signed [33:0]  h_s;
    logic                inr [2];
    logic                inh [2];
    logic [31:0]         setm;
    logic [31:0]         rstm;

    // BCD window to binary; non-decimal digits still weigh in
    assign wlen = 14'(q.wbcd[15:12]) * 14'd1000 + 14'(q.wbcd[11:8]) * 14'd100
                + 14'(q.wbcd[7:4]) * 14'd10 + 14'(q.wbcd[3:0]); // R1
    assign ms_tick = (q.tick == 32'(MS_CYCLES - 1));
    assign win_end = (q.ph == crm_pkg::CRM_RUN) && ms_tick
                   && (q.wcnt + 14'h0001 >= wlen);

    // Ring span fold; with full 32-bit span plain modulo is already right
    assign raw  = 34'(signed'({2'b00, count_in})) - 34'(signed'({2'b00, q.start}));
    assign span = 34'(signed'({2'b00, q.ring})) + 34'sh1;
    assign half = span >>> 1;
    always_comb begin
        fixed = raw;
        if (q.ctrl[`CRM_CTRL_RING]) begin
            if (raw >= half) begin
                fixed = raw - span; // R5
            end else if (raw < -half) begin
                fixed = raw + span; // R5
            end
        end
    end

    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    assign wr_go = hsel && hready && htrans[1] && hwrite;
    assign rofs  = {haddr[5:2], 2'b00};
    assign hidx  = q.wptr - 6'h01 - q.hsel; // R9

    // Range tests in 34 bits so hysteresis cannot overflow
    assign r_s = 34'(signed'(q.rate)); // R14
    assign h_s = (q.ctrl[`CRM_CTRL_RMODE]) ? 34'(q.hyst) : 34'sh0; // R21
    always_comb begin
        setm = 32'h00000000;
        rstm = 32'h00000000;
        for (int i = 0; i < 2; i++) begin
            lo_s[i] = 34'(signed'(q.rng[i][127:96])); // R14
            hi_s[i] = 34'(signed'(q.rng[i][95:64]));
            inr[i]  = (lo_s[i] <= r_s) && (r_s <= hi_s[i]); // R13
            inh[i]  = (lo_s[i] - h_s <= r_s) && (r_s <= hi_s[i] + h_s); // R19
            if (q.act[i] && q.ctrl[i]) begin // R18
                setm = setm | q.rng[i][63:32]; // R16
                rstm = rstm | q.rng[i][31:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux for the address phase

    always_comb begin
        rv = 32'h00000000;
        if (rofs == `CRM_CTRL_OFS) begin
            rv = {28'h0000000, q.ctrl};
        end else if (rofs == `CRM_WIN_OFS) begin
            rv = {16'h0000, q.wbcd};
        end else if (rofs == `CRM_HYST_OFS) begin
            rv = {24'h000000, q.hyst};
        end else if (rofs == `CRM_STAT_OFS) begin
            rv = {16'h0000, 1'b0, q.hcnt, 1'b0, q.ph != crm_pkg::CRM_IDLE,
                  1'b0, q.err, q.act}; // R13
        end else if (rofs == `CRM_RATE_OFS) begin
            rv = q.rate;
        end else if (rofs == `CRM_HSEL_OFS) begin
            rv = {26'h0000000, q.hsel};
        end else if (rofs == `CRM_HDAT_OFS) begin
            rv = (7'(q.hsel) < q.hcnt) ? q.hist[hidx] : 32'h00000000; // R9
        end else if (rofs == `CRM_RING_OFS) begin
            rv = q.ring;
        end else if (rofs[5] == 1'b1) begin
            rv = q.rng[rofs[4]][127 - 32 * rofs[3:2] -: 32]; // R10
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d      = q;
        d.push = 1'b0;
        d.tick = ms_tick ? 32'h00000000 : q.tick + 32'h00000001;

        // Bus write, data phase of the previous address phase
        if (q.wpend) begin
            if (q.waddr == `CRM_CTRL_OFS) begin
                d.ctrl = hwdata[3:0];
            end else if (q.waddr == `CRM_WIN_OFS) begin
                d.wbcd = hwdata[15:0]; // R1
                d.ph   = crm_pkg::CRM_IDLE;
            end else if (q.waddr == `CRM_HYST_OFS) begin
                d.hyst = hwdata[7:0]; // R19
            end else if (q.waddr == `CRM_HSEL_OFS) begin
                d.hsel = hwdata[5:0];
            end else if (q.waddr == `CRM_RING_OFS) begin
                d.ring = hwdata;
            end else if (q.waddr[5] == 1'b1) begin
                d.rng[q.waddr[4]][127 - 32 * q.waddr[3:2] -: 32] = hwdata; // R10
            end
        end
        d.wpend = wr_go;
        d.waddr = rofs;
        d.rdata = rd_go ? rv : 32'h00000000;

        // Measurement sequence
        case (q.ph)
            crm_pkg::CRM_IDLE: begin
                if (wlen != 14'h0000 && !(q.wpend && q.waddr == `CRM_WIN_OFS)) begin
                    d.ph = crm_pkg::CRM_ARM; // R3
                end
            end
            crm_pkg::CRM_ARM: begin
                // Aligning the ms tick to the start keeps the window exact
                d.start = count_in;
                d.tick  = 32'h00000000; // R6
                d.wcnt  = 14'h0000;
                d.ph    = crm_pkg::CRM_RUN;
            end
            crm_pkg::CRM_RUN: begin
                if (ms_tick) begin
                    d.wcnt = q.wcnt + 14'h0001;
                end
                if (win_end) begin
                    d.rate  = 32'(fixed); // R2
                    d.start = count_in; // R23
                    d.wcnt  = 14'h0000;
                    d.push  = 1'b1;
                    d.hist[q.wptr] = 32'(fixed); // R7
                    d.wptr  = q.wptr + 6'h01; // R8
                    if (q.hcnt != 7'(`CRM_HIST_DEPTH)) begin
                        d.hcnt = q.hcnt + 7'h01;
                    end
                end
            end
            default: begin
                d.ph = crm_pkg::CRM_IDLE;
            end
        endcase

        // Preset drops the window in flight; the last rate stays
        if (count_load && q.ph == crm_pkg::CRM_RUN) begin
            d.ph   = crm_pkg::CRM_ARM; // R4
            d.rate = q.rate;
            d.push = 1'b0;
            d.hist = q.hist;
            d.wptr = q.wptr;
            d.hcnt = q.hcnt;
        end
        if (wlen == 14'h0000) begin
            d.ph = crm_pkg::CRM_IDLE; // R3
        end

        // Range activity: enter inside limits, leave only past hysteresis
        for (int i = 0; i < 2; i++) begin
            d.act[i] = q.act[i] ? inh[i] : inr[i]; // R20
        end
        d.err[0] = ($signed(q.rng[0][95:64]) <= $signed(q.rng[0][127:96])); // R11
        d.err[1] = ($signed(q.rng[1][95:64]) <= $signed(q.rng[1][127:96])); // R11
        d.err[2] = (lo_s[0] <= hi_s[1]) && (lo_s[1] <= hi_s[0]); // R12

        // Reset beats set on the same bit, as for preset patterns
        d.outp = (unit_pat | setm) & ~rstm; // R17
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q      <= '0;
            q.ph   <= crm_pkg::CRM_IDLE;
            q.ctrl <= `CRM_CTRL_RST; // R18
            q.wbcd <= `CRM_WIN_RST; // R3
            q.hyst <= `CRM_HYST_RST;
            q.ring <= `CRM_RING_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops; hreadyout and hresp are tied constants
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = q.rdata;
    assign out_pat      = q.outp; // R15
    assign range_active = q.act;
    assign cfg_err      = q.err;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    idle_no_rate_a: assert property (wlen == 14'h0000 |=> $stable(q.rate)) // R3
        else $error("rate changed with window off");
    load_keeps_rate_a: assert property (count_load |=> $stable(q.rate)) // R4
        else $error("rate changed on preset");
    rate_diff_a: assert property ( // R2
        win_end && !count_load && !q.ctrl[`CRM_CTRL_RING] && wlen != 14'h0000
        |=> q.rate == $past(count_in) - $past(q.start) && q.start == $past(count_in))
        else $error("rate is not end minus start");
    hist_newest_a: assert property (q.push |-> q.hist[q.wptr - 6'h01] == q.rate) // R7
        else $error("newest history entry differs from rate");
    hist_full_a: assert property (q.hcnt <= 7'(`CRM_HIST_DEPTH)) // R8
        else $error("history count above depth");
    limit_order_a: assert property ( // R11
        $past(hresetn) |-> ##1 q.err[0] == ($signed($past(q.rng[0][95:64]))
                         <= $signed($past(q.rng[0][127:96]))))
        else $error("range order error flag wrong");
    overlap_flag_a: assert property ( // R12
        ($past(hresetn) && $stable(q.rng)) ##1 $stable(q.rng)
        |-> q.err[2] == ((lo_s[0] <= hi_s[1]) && (lo_s[1] <= hi_s[0])))
        else $error("overlap flag wrong");
    reset_wins_a: assert property ( // R16
        q.act[0] && q.ctrl[0] && q.rng[0][1] |=> !q.outp[1])
        else $error("reset pattern did not clear output");
    disabled_pass_a: assert property ( // R18
        $past(hresetn) && q.ctrl[1:0] == 2'b00 |=> q.outp == $past(unit_pat))
        else $error("disabled ranges changed outputs");
    cmp_no_hyst_a: assert property ( // R21
        $past(hresetn) && !q.ctrl[`CRM_CTRL_RMODE] |=> q.act[0] == $past(inr[0]))
        else $error("hysteresis acted in comparison mode");
    window_len_a: assert property ( // R6
        q.ph == crm_pkg::CRM_RUN && q.wcnt >= wlen |-> !ms_tick || win_end)
        else $error("window overran its length");

endmodule : crm_top

// ---- bench/crm_host.sv ----
// Host CPU model: an AHB-Lite master doing single word transfers.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/10ps

module crm_host (
    // Clock and bus return
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Bus request
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One transfer; no latency assumed, the slave may stall at will
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= w ? wd : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        hwdata <= ~hwdata;  // Stale data must not look valid
    endtask : xfer
endmodule : crm_host

// ---- bench/crm_top_bench.sv ----
// Self-checking bench of the rate monitor: bus, windows, ranges, hysteresis.
// Assumes the host model and a millisecond shortened to MS cycles.
`timescale 1ns/10ps

module crm_top_bench;
    localparam int MS = 10;

    // Clock, reset and pins
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        count_load = 1'b0;
    logic [31:0] count_in = 32'h5;
    logic [31:0] unit_pat = 32'hF0F00002;
    logic        hsel, hwrite, hreadyout, hresp;
    logic [1:0]  htrans, range_active;
    logic [2:0]  hsize, cfg_err;
    logic [31:0] haddr, hwdata, hrdata, out_pat;
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc = 0;

    ////////////////////////////////////////////////////////////////////////
    // Design and host
    crm_top #(.MS_CYCLES(MS)) i_crm_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .count_in(count_in), .count_load(count_load), .unit_pat(unit_pat),
        .out_pat(out_pat), .range_active(range_active), .cfg_err(cfg_err));
    crm_host i_crm_host (
        .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    // 200 MHz clock
    always #2.5 hclk = ~hclk;

    // Hang guard, far above the expected run
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        i_crm_host.xfer(1'b1, a, d, unused);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        i_crm_host.xfer(1'b0, a, 32'h0, d);
    endtask : rd

    // Polls the history count until one more rate is logged
    task automatic wait_push();
        logic [31:0] s0, s;
        rd(8'h0C, s0);
        s = s0;
        for (int k = 0; k < 100 && s[14:8] === s0[14:8]; k++) rd(8'h0C, s);
        check(32'(s[14:8] !== s0[14:8]), 32'h1);
    endtask : wait_push

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        logic [31:0] v;
        logic [7:0]  a [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C};
        logic [31:0] e [5] = '{32'h0, 32'h0, 32'h0, 32'h1F, 32'hFFFFFFFF};
        for (int i = 0; i < 5; i++) begin
            rd(a[i], v);
            check(v, e[i]);
        end
        check(out_pat, unit_pat);
    endtask : t_reset

    // Reversal inside a window, preset keeps the rate, then stop
    task automatic t_rate();
        logic [31:0] v;
        realtime     t0;
        int          n;
        wr(8'h04, 32'h0005);  // five ms in BCD
        t0 = $realtime;
        repeat (5) @(posedge hclk);
        count_in <= 32'hFFFFFFFB;
        wait_push();
        n = int'(($realtime - t0) / 5.0);
        check(32'(n >= 4 * MS && n <= 6 * MS + 6), 32'h1);
        rd(8'h10, v);
        check(v, 32'hFFFFFFF6);
        count_in   <= 32'h3E8;  // hysteresis still off here
        count_load <= 1'b1;
        @(posedge hclk);
        count_load <= 1'b0;
        rd(8'h10, v);
        check(v, 32'hFFFFFFF6);
        wr(8'h04, 32'h0);
        rd(8'h0C, v);
        check({17'h0, v[14:8], 1'b0, v[6], 6'h0}, 32'h100);
        wr(8'h14, 32'h0);
        rd(8'h18, v);
        check(v, 32'hFFFFFFF6);
    endtask : t_rate

    // Rate stays at minus ten: range zero hit, range one clear
    task automatic t_range();
        logic [31:0] r [8] = '{32'hFFFFFFEC, 32'hFFFFFFFF, 32'h7, 32'h2,
                               32'h0, 32'h64, 32'h0, 32'h0};
        for (int i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), r[i]);
        wr(8'h00, 32'h3);
        repeat (3) @(posedge hclk);
        check({29'h0, cfg_err}, 32'h0);
        check({30'h0, range_active}, 32'h1);
        check(out_pat, 32'hF0F00005);
        wr(8'h30, 32'hFFFFFFFF);
        repeat (3) @(posedge hclk);
        check({29'h0, cfg_err}, 32'h4);
        wr(8'h30, 32'h64);
        repeat (3) @(posedge hclk);
        check({29'h0, cfg_err}, 32'h2);
        wr(8'h30, 32'h0);
        wr(8'h00, 32'h2);
        repeat (3) @(posedge hclk);
        check(out_pat, unit_pat);
    endtask : t_range

    // Rate rises to zero, just past the upper limit of range zero
    task automatic t_hyst();
        logic [31:0] v;
        wr(8'h08, 32'h5);
        wr(8'h00, 32'h5);
        wr(8'h04, 32'h0001);
        wait_push();
        wr(8'h04, 32'h0);
        rd(8'h10, v);
        check(v, 32'h0);
        check({30'h0, range_active}, 32'h3);
        wr(8'h00, 32'h1);
        repeat (3) @(posedge hclk);
        check({30'h0, range_active}, 32'h2);
        wr(8'h08, 32'h0);
    endtask : t_hyst

    // Ring of 256 counts rolling over upward
    task automatic t_ring();
        logic [31:0] v;
        @(posedge hclk);
        count_in <= 32'hFA;
        wr(8'h1C, 32'hFF);
        wr(8'h00, 32'h8);
        wr(8'h04, 32'h0005);
        repeat (5) @(posedge hclk);
        count_in <= 32'h4;
        wait_push();
        rd(8'h10, v);
        check(v, 32'hA);
        wr(8'h14, 32'h1);
        rd(8'h18, v);
        check(v, 32'h0);
    endtask : t_ring

    // Long run of 1 ms windows fills the history and wraps it
    task automatic t_wrap();
        logic [31:0] v;
        wr(8'h04, 32'h0001);
        repeat (70 * MS + 20) @(posedge hclk);
        wr(8'h04, 32'h0);
        rd(8'h0C, v);
        check(32'(v[14:8]), 32'h40);
        wr(8'h14, 32'h3F);
        rd(8'h18, v);
        check(v, 32'h0);
        rd(8'h14, v);
        check(v, 32'h3F);
    endtask : t_wrap

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        $display("t_reset done");
        t_rate();
        $display("t_rate done");
        t_range();
        $display("t_range done");
        t_hyst();
        $display("t_hyst done");
        t_ring();
        $display("t_ring done");
        t_wrap();
        $display("t_wrap done");
        check({31'h0, hresp}, 32'h0);
        stop_test();
    end
endmodule : crm_top_bench
